// File: rtl/hs_timer_preset_control.sv
// Interval timer control, preset sequencer and AXI4-Lite register file
`timescale 1ns/10ps

// Contract
// - interval is unsigned 32 bit, 0.01 us LSB
// - valid rises one cycle after active
// - valid and active drop on stop/fault
// - active set on run rising edge
// - invalid setup raises fault with code
// - fault cleared only on run falling edge
// - interval refreshed on updates while valid
// - fault halts measurement and stays latched
// - channel sampled at start; null faults
// - measure pulses on selected channel input
// - status resets deasserted, code no fault
// - trigger 0 loads preset right away
// - trigger 1 defers load to external
// - done once counter holds preset
// - aborted set when pending preset aborted
// - preset active while pending
// - external load on index rising edge
// - request low clears done/active/aborted
module hs_timer_preset_control (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire hs_timer_pkg::axil_req_t axil_req_i,
  output hs_timer_pkg::axil_rsp_t axil_rsp_o,
  input wire logic [hs_timer_pkg::NUM_TIN-1:0] timer_in_i,
  input wire logic index_z_i,
  input wire logic count_pulse_i,
  output logic [31:0] counter_value_o
);
  import hs_timer_pkg::*;

  function automatic logic [31:0] apply_strb(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    return (addr[1:0] == 2'h0) && (addr <= CNT_VALUE_OFS);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [NUM_PIN-1:0] pin_meta;
  logic [NUM_PIN-1:0] pin_sync;
  logic [NUM_PIN-1:0] pin_last;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_meta <= '0;
      pin_sync <= '0;
      pin_last <= '0;
    end else begin
      pin_meta <= {count_pulse_i, index_z_i, timer_in_i};
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic aw_held, w_held, bvalid, rvalid, awready, wready, arready, wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data, rdata, next_rdata;
  logic [3:0] wr_strb;
  logic [1:0] bresp, rresp;

  assign awready = ~aw_held & ~bvalid;
  assign wready = ~w_held & ~bvalid;
  assign arready = ~rvalid;
  assign wr_en = aw_held & w_held & ~bvalid;
  assign axil_rsp_o = '{awready: awready, wready: wready, bresp: bresp,
                        bvalid: bvalid, arready: arready, rdata: rdata,
                        rresp: rresp, rvalid: rvalid};

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      aw_held <= 1'b0;
      wr_addr <= 8'h00;
    end else if (axil_req_i.awvalid && awready) begin
      aw_held <= 1'b1;
      wr_addr <= axil_req_i.awaddr;
    end else if (wr_en) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      w_held <= 1'b0;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end else if (axil_req_i.wvalid && wready) begin
      w_held <= 1'b1;
      wr_data <= axil_req_i.wdata;
      wr_strb <= axil_req_i.wstrb;
    end else if (wr_en) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wr_en) begin
      bvalid <= 1'b1;
      bresp <= mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (axil_req_i.bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (axil_req_i.arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= next_rdata;
      rresp <= mapped(axil_req_i.araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (axil_req_i.rready) begin
      rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [31:0] tmr_ctrl, pre_ctrl, preset_count;
  logic run_request, preset_request, abort_cmd;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tmr_ctrl <= CTRL_RST;
      pre_ctrl <= CTRL_RST;
      preset_count <= CTRL_RST;
    end else if (wr_en) begin
      if (wr_addr == TMR_CTRL_OFS) begin
        tmr_ctrl <= apply_strb(tmr_ctrl, wr_data, wr_strb) & TMR_CTRL_MASK;
      end
      if (wr_addr == PRE_CTRL_OFS) begin
        pre_ctrl <= apply_strb(pre_ctrl, wr_data, wr_strb) & PRE_CTRL_MASK;
      end
      if (wr_addr == PRE_COUNT_OFS) begin
        preset_count <= apply_strb(preset_count, wr_data, wr_strb);
      end
    end
  end

  assign run_request = tmr_ctrl[RUN_BIT];
  assign preset_request = pre_ctrl[REQ_BIT];
  assign abort_cmd = wr_en && (wr_addr == PRE_CTRL_OFS) && wr_strb[0] &&
                     wr_data[ABORT_BIT];

  // ----------------------------------------------------------------
  // Interval timer control
  // ----------------------------------------------------------------
  logic run_prev, run_rise, run_fall, t_active, t_valid, t_fault;
  fault_code_enum_t t_code;
  logic [2:0] t_handle;
  timer_mode_t t_mode;

  assign run_rise = run_request & ~run_prev;
  assign run_fall = ~run_request & run_prev;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      run_prev <= 1'b0;
      t_valid <= 1'b0;
    end else begin
      run_prev <= run_request;
      t_valid <= t_active & run_request & ~t_fault;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      t_active <= 1'b0;
      t_fault <= 1'b0;
      t_code <= NO_FAULT_CODE;
      t_handle <= 3'h0;
      t_mode <= MODE_UP_DOWN;
    end else begin
      if (run_fall) begin
        t_fault <= 1'b0;
        t_code <= NO_FAULT_CODE;
      end
      if (!run_request || t_fault) begin
        t_active <= 1'b0;
      end else if (run_rise && !t_active) begin
        if (tmr_ctrl[THANDLE_LSB +: 3] == 3'h0) begin
          t_fault <= 1'b1;
          t_code <= NULL_HANDLE;
        end else begin
          t_active <= 1'b1;
          t_handle <= tmr_ctrl[THANDLE_LSB +: 3];
          t_mode <= timer_mode_t'(tmr_ctrl[TMODE_BIT]);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Interval measurement
  // ----------------------------------------------------------------
  logic sel_now, sel_last, sel_rise, sel_fall, end_edge, measuring, tick;
  logic [7:0] tick_cnt;
  logic [31:0] span, measured_interval;

  assign sel_now = pin_sync[t_handle - 3'h1];
  assign sel_last = pin_last[t_handle - 3'h1];
  assign sel_rise = sel_now & ~sel_last;
  assign sel_fall = ~sel_now & sel_last;
  assign end_edge = (t_mode == MODE_UP_DOWN) ? sel_fall : sel_rise;
  assign tick = (tick_cnt == TICK_LAST);

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      measuring <= 1'b0;
      span <= 32'h0000_0000;
      tick_cnt <= 8'h00;
    end else if (!t_active) begin
      measuring <= 1'b0;
      span <= 32'h0000_0000;
      tick_cnt <= 8'h00;
    end else if (sel_rise) begin
      measuring <= 1'b1;
      span <= 32'h0000_0000;
      tick_cnt <= 8'h00;
    end else begin
      tick_cnt <= tick ? 8'h00 : tick_cnt + 8'h01;
      if (measuring && tick && span != 32'hFFFF_FFFF) begin
        span <= span + 32'h0000_0001;
      end
      if (sel_fall && t_mode == MODE_UP_DOWN) begin
        measuring <= 1'b0;
      end
    end
  end

  // Unsigned count of 10 ns ticks up to the closing edge
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      measured_interval <= 32'h0000_0000;
    end else if (t_valid && measuring && end_edge) begin
      measured_interval <= span + {31'h0, tick};
    end
  end

  // ----------------------------------------------------------------
  // Preset sequencer and counter
  // ----------------------------------------------------------------
  preset_state_t p_state;
  logic pre_prev, pre_rise, pre_fall, z_rise, count_rise, load_now;
  logic p_active, p_done, p_aborted, p_fault;
  fault_code_enum_t p_code;
  logic [1:0] req_trig;
  logic [31:0] p_value, cnt;

  assign pre_rise = preset_request & ~pre_prev;
  assign pre_fall = ~preset_request & pre_prev;
  assign z_rise = pin_sync[Z_IDX] & ~pin_last[Z_IDX];
  assign count_rise = pin_sync[CNT_IDX] & ~pin_last[CNT_IDX];
  // A request dropped in the load cycle must not move the counter
  assign load_now = preset_request && ((p_state == P_LOAD) ||
                    (p_state == P_WAIT_Z && z_rise));
  assign p_active = (p_state == P_LOAD) || (p_state == P_WAIT_Z);
  assign req_trig = pre_ctrl[TRIG_LSB +: 2];

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pre_prev <= 1'b0;
      p_state <= P_IDLE;
      p_done <= 1'b0;
      p_aborted <= 1'b0;
      p_fault <= 1'b0;
      p_code <= NO_FAULT_CODE;
      p_value <= 32'h0000_0000;
    end else begin
      pre_prev <= preset_request;
      if (pre_fall) begin
        p_state <= P_IDLE;
        p_done <= 1'b0;
        p_aborted <= 1'b0;
        p_fault <= 1'b0;
        p_code <= NO_FAULT_CODE;
      end else if (pre_rise && !p_active) begin
        p_value <= preset_count;
        if (pre_ctrl[PHANDLE_LSB +: 2] == 2'h0) begin
          p_fault <= 1'b1;
          p_code <= NULL_HANDLE;
        end else if (req_trig > TRIG_EXTERNAL) begin
          p_fault <= 1'b1;
          p_code <= BAD_TRIGGER;
        end else if (req_trig == TRIG_EXECUTE) begin
          p_state <= P_LOAD;
        end else begin
          p_state <= P_WAIT_Z;
        end
      end else if (load_now) begin
        p_state <= P_ENDED;
        p_done <= 1'b1;
      end else if (p_state == P_WAIT_Z && abort_cmd) begin
        p_state <= P_ENDED;
        p_aborted <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt <= 32'h0000_0000;
    end else if (load_now) begin
      cnt <= p_value;
    end else if (count_rise) begin
      cnt <= cnt + 32'h0000_0001;
    end
  end

  assign counter_value_o = cnt;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (axil_req_i.araddr)
      TMR_CTRL_OFS: next_rdata = tmr_ctrl;
      TMR_STAT_OFS: begin
        next_rdata[ST_VALID] = t_valid;
        next_rdata[ST_ACTIVE] = t_active;
        next_rdata[ST_FAULT] = t_fault;
        next_rdata[ST_CODE_LSB +: 8] = t_code;
      end
      TMR_VALUE_OFS: next_rdata = measured_interval;
      PRE_CTRL_OFS: next_rdata = pre_ctrl;
      PRE_COUNT_OFS: next_rdata = preset_count;
      PRE_STAT_OFS: begin
        next_rdata[ST_DONE] = p_done;
        next_rdata[ST_PACTIVE] = p_active;
        next_rdata[ST_ABORTED] = p_aborted;
        next_rdata[ST_PFAULT] = p_fault;
        next_rdata[ST_CODE_LSB +: 8] = p_code;
      end
      CNT_VALUE_OFS: next_rdata = cnt;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_exec_start;
    pre_rise && !p_active && pre_ctrl[PHANDLE_LSB +: 2] != 2'h0 &&
      req_trig == TRIG_EXECUTE;
  endsequence

  sequence s_z_start;
    pre_rise && !p_active && pre_ctrl[PHANDLE_LSB +: 2] != 2'h0 &&
      req_trig == TRIG_EXTERNAL;
  endsequence

  a_valid_follow: assert property (
    $rose(t_active) && run_request && !t_fault |=> t_valid)
    else $error("valid did not follow active");
  a_stop_drop: assert property (
    !run_request |=> !t_valid && !t_active)
    else $error("valid or active stayed after stop");
  a_fault_code: assert property (
    t_fault == (t_code != NO_FAULT_CODE))
    else $error("fault flag and code disagree");
  a_fault_clear: assert property (
    $fell(t_fault) |-> $past(run_fall))
    else $error("fault cleared without run falling");
  a_fault_halt: assert property (
    t_fault |-> !t_active && !t_valid && !measuring)
    else $error("measurement running under fault");
  a_null_handle: assert property (
    run_rise && !t_active && tmr_ctrl[THANDLE_LSB +: 3] == 3'h0 |=> t_fault)
    else $error("null channel accepted");
  a_meas_hold: assert property (
    !t_valid |=> $stable(measured_interval))
    else $error("interval changed while not valid");
  a_exec_load: assert property (
    s_exec_start ##1 preset_request |=> cnt == p_value && p_done)
    else $error("immediate preset not loaded");
  a_z_wait: assert property (
    s_z_start ##1 (preset_request && !z_rise) |=> !p_done && p_active)
    else $error("external preset did not wait");
  a_z_load: assert property (
    p_state == P_WAIT_Z && z_rise && preset_request
      |=> p_done && cnt == p_value)
    else $error("index edge did not load preset");
  a_pre_clear: assert property (
    pre_fall |=> !p_done && !p_active && !p_aborted)
    else $error("preset status not cleared");

endmodule

// File: include/hs_timer_pkg.sv
// Shared types, register map and constants of the timer and preset block
package hs_timer_pkg;

  // ----------------------------------------------------------------
  // AXI4-Lite carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } axil_rsp_t;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] TMR_CTRL_OFS = 8'h00;
  localparam logic [7:0] TMR_STAT_OFS = 8'h04;
  localparam logic [7:0] TMR_VALUE_OFS = 8'h08;
  localparam logic [7:0] PRE_CTRL_OFS = 8'h0C;
  localparam logic [7:0] PRE_COUNT_OFS = 8'h10;
  localparam logic [7:0] PRE_STAT_OFS = 8'h14;
  localparam logic [7:0] CNT_VALUE_OFS = 8'h18;

  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] TMR_CTRL_MASK = 32'h0000_0073;
  localparam logic [31:0] PRE_CTRL_MASK = 32'h0000_0331;

  localparam int RUN_BIT = 0;
  localparam int TMODE_BIT = 1;
  localparam int THANDLE_LSB = 4;
  localparam int REQ_BIT = 0;
  localparam int ABORT_BIT = 1;
  localparam int TRIG_LSB = 4;
  localparam int PHANDLE_LSB = 8;

  localparam int ST_VALID = 0;
  localparam int ST_ACTIVE = 1;
  localparam int ST_FAULT = 2;
  localparam int ST_DONE = 0;
  localparam int ST_PACTIVE = 1;
  localparam int ST_ABORTED = 2;
  localparam int ST_PFAULT = 3;
  localparam int ST_CODE_LSB = 8;

  // ----------------------------------------------------------------
  // Codes, modes and states
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    NO_FAULT_CODE = 8'h00,
    NULL_HANDLE = 8'h01,
    BAD_TRIGGER = 8'h02
  } fault_code_enum_t;

  typedef enum logic {MODE_UP_DOWN, MODE_UP_UP} timer_mode_t;

  localparam logic [1:0] TRIG_EXECUTE = 2'h0;
  localparam logic [1:0] TRIG_EXTERNAL = 2'h1;

  typedef enum logic [1:0] {P_IDLE, P_LOAD, P_WAIT_Z, P_ENDED} preset_state_t;

  // ----------------------------------------------------------------
  // Pins and timing
  // ----------------------------------------------------------------
  localparam int NUM_TIN = 7;
  localparam int NUM_PIN = NUM_TIN + 2;
  localparam int Z_IDX = NUM_TIN;
  localparam int CNT_IDX = NUM_TIN + 1;
  localparam int CLK_PERIOD_PS = 10000;
  localparam int LSB_PS = 10000;
  localparam int TICKS_PER_LSB = (LSB_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [7:0] TICK_LAST = 8'(TICKS_PER_LSB - 1);

endpackage

// File: dv/pulse_source.sv
// Model of the pins outside the block: timer inputs, index and count pins
`timescale 1ns/10ps
module pulse_source (
  input wire logic clk_i,
  output logic [hs_timer_pkg::NUM_TIN-1:0] timer_in_o,
  output logic index_z_o,
  output logic count_pulse_o
);
  import hs_timer_pkg::*;
  initial begin
    timer_in_o = '0;
    index_z_o = 1'b0;
    count_pulse_o = 1'b0;
  end
  // ----------------------------------------------------------------
  // Pin wave tasks
  // ----------------------------------------------------------------
  // High for hi cycles, then low for lo cycles; a rise every hi+lo+1
  task automatic pulse(input int ch, input int hi, input int lo);
    @(posedge clk_i);
    timer_in_o[ch] <= 1'b1;
    repeat (hi) @(posedge clk_i);
    timer_in_o[ch] <= 1'b0;
    repeat (lo) @(posedge clk_i);
  endtask
  task automatic pulse_z();
    @(posedge clk_i);
    index_z_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    index_z_o <= 1'b0;
  endtask
  task automatic count(input int n);
    repeat (n) begin
      @(posedge clk_i);
      count_pulse_o <= 1'b1;
      repeat (2) @(posedge clk_i);
      count_pulse_o <= 1'b0;
      @(posedge clk_i);
    end
  endtask
endmodule

// File: dv/tb_top.sv
// Self-checking bench of the timer and preset block
`timescale 1ns/10ps
module tb_top;
  import hs_timer_pkg::*;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  axil_req_t req = '0;
  axil_rsp_t rsp;
  logic [NUM_TIN-1:0] tin;
  logic index_z;
  logic count_pulse;
  logic [31:0] cnt_value;
  logic [31:0] rd;
  logic [1:0] resp;
  int err_total = 0;
  int n_compared = 0;

  always #5 sys_clk_i = ~sys_clk_i;

  hs_timer_preset_control uut (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .axil_req_i(req),
    .axil_rsp_o(rsp),
    .timer_in_i(tin),
    .index_z_i(index_z),
    .count_pulse_i(count_pulse),
    .counter_value_o(cnt_value)
  );
  pulse_source src (
    .clk_i(sys_clk_i),
    .timer_in_o(tin),
    .index_z_o(index_z),
    .count_pulse_o(count_pulse)
  );
  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk_word(input string what, input logic [31:0] exp,
                          input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_resp(input string what, input logic [1:0] exp,
                          input logic [1:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s response expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_test(input string s);
    $display("test %s done, mismatches so far %0d", s, err_total);
  endtask
  task automatic bound(input int n);
    if (n >= 100) begin
      err_total++;
      $display("Error bus answer expected within 100 cycles seen none");
      stop_test();
    end
  endtask
  // ----------------------------------------------------------------
  // Bus master
  // ----------------------------------------------------------------
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      n++;
      bound(n);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    resp = rsp.bresp;
    req.bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      n++;
      bound(n);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    rd = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                        input string what);
    axi_read(a);
    chk_resp(what, RESP_OKAY, resp);
    chk_word(what, exp, rd);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  // ----------------------------------------------------------------
  // Expected values
  // ----------------------------------------------------------------
  function automatic logic [31:0] stat(input logic [3:0] b,
                                       input logic [7:0] code);
    return 32'(b) | (32'(code) << ST_CODE_LSB);
  endfunction
  function automatic logic [31:0] pctl(input logic ab, input logic [1:0] tr,
                                       input logic [1:0] hd);
    return 32'h1 | (32'(ab) << ABORT_BIT) | (32'(tr) << TRIG_LSB)
           | (32'(hd) << PHANDLE_LSB);
  endfunction
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] pc;
    logic [31:0] ev;
    int h;
    int w1;
    int w2;
    int lo;
    void'($urandom(83));
    repeat (3) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    rd_chk(TMR_STAT_OFS, 32'h0, "timer status");
    rd_chk(PRE_STAT_OFS, 32'h0, "preset status");
    rd_chk(TMR_VALUE_OFS, 32'h0, "interval");
    rd_chk(PRE_COUNT_OFS, 32'h0, "preset count");
    axi_read(8'h1C);
    chk_resp("unmapped read", RESP_SLVERR, resp);
    chk_word("unmapped data", 32'h0, rd);
    axi_write(TMR_VALUE_OFS, 32'hFFFF_FFFF);
    chk_resp("read-only write", RESP_OKAY, resp);
    axi_write(8'h1C, 32'hFFFF_FFFF);
    chk_resp("unmapped write", RESP_SLVERR, resp);
    rd_chk(TMR_VALUE_OFS, 32'h0, "interval kept");
    end_test("reset and map");
    axi_write(TMR_CTRL_OFS, 32'h1);
    idle(4);
    rd_chk(TMR_STAT_OFS, stat(4'h4, NULL_HANDLE), "null");
    axi_write(TMR_CTRL_OFS, 32'h31);
    idle(4);
    rd_chk(TMR_STAT_OFS, stat(4'h4, NULL_HANDLE), "held");
    axi_write(TMR_CTRL_OFS, 32'h0);
    idle(4);
    rd_chk(TMR_STAT_OFS, 32'h0, "fault clear");
    end_test("timer fault");
    for (int m = 0; m < 2; m++) begin
      h = $urandom_range(1, NUM_TIN);
      w1 = $urandom_range(1, 40);
      w2 = w1 + $urandom_range(1, 9);
      lo = $urandom_range(4, 20);
      axi_write(TMR_CTRL_OFS, 32'(1 | (m << TMODE_BIT) | (h << THANDLE_LSB)));
      idle(4);
      rd_chk(TMR_STAT_OFS, stat(4'h3, NO_FAULT_CODE), "run");
      src.pulse(h - 1, w1, lo);
      src.pulse(h - 1, w2, lo);
      idle(8);
      ev = (m == 0) ? 32'(w2) : 32'(w1 + lo + 1);
      rd_chk(TMR_VALUE_OFS, ev, "interval");
      src.pulse(h % NUM_TIN, 5, 5);
      idle(8);
      rd_chk(TMR_VALUE_OFS, ev, "other pin");
      axi_write(TMR_CTRL_OFS, 32'(h << THANDLE_LSB));
      idle(4);
      rd_chk(TMR_STAT_OFS, 32'h0, "stop");
    end
    end_test("timer measure");
    src.count($urandom_range(3, 12));
    pc = $urandom();
    axi_write(PRE_COUNT_OFS, pc);
    axi_write(PRE_CTRL_OFS, pctl(1'b0, TRIG_EXECUTE, 2'h1));
    idle(4);
    rd_chk(PRE_STAT_OFS, stat(4'h1, NO_FAULT_CODE), "done");
    chk_word("counter preset", pc, cnt_value);
    axi_write(PRE_COUNT_OFS, ~pc);
    axi_write(PRE_CTRL_OFS, pctl(1'b0, TRIG_EXECUTE, 2'h1));
    idle(4);
    chk_word("no reload", pc, cnt_value);
    axi_write(PRE_CTRL_OFS, 32'h0);
    idle(4);
    rd_chk(PRE_STAT_OFS, 32'h0, "release");
    end_test("preset immediate");
    axi_write(PRE_COUNT_OFS, 32'h8000_0000);
    src.count(2);
    axi_write(PRE_CTRL_OFS, pctl(1'b0, TRIG_EXTERNAL, 2'h2));
    idle(4);
    rd_chk(PRE_STAT_OFS, stat(4'h2, NO_FAULT_CODE), "wait");
    chk_word("counter held", pc + 32'h2, cnt_value);
    src.pulse_z();
    idle(6);
    rd_chk(PRE_STAT_OFS, stat(4'h1, NO_FAULT_CODE), "z done");
    chk_word("counter z", 32'h8000_0000, cnt_value);
    axi_write(PRE_CTRL_OFS, 32'h0);
    axi_write(PRE_CTRL_OFS, pctl(1'b0, TRIG_EXTERNAL, 2'h3));
    axi_write(PRE_CTRL_OFS, pctl(1'b1, TRIG_EXTERNAL, 2'h3));
    idle(4);
    rd_chk(PRE_STAT_OFS, stat(4'h4, NO_FAULT_CODE), "aborted");
    src.count(1);
    src.pulse_z();
    idle(6);
    chk_word("no load", 32'h8000_0001, cnt_value);
    axi_write(PRE_CTRL_OFS, 32'h0);
    idle(4);
    rd_chk(PRE_STAT_OFS, 32'h0, "abort clear");
    end_test("preset external");
    for (int k = 0; k < 2; k++) begin
      axi_write(PRE_CTRL_OFS, k ? pctl(1'b0, 2'h2, 2'h1)
                                : pctl(1'b0, TRIG_EXECUTE, 2'h0));
      idle(4);
      rd_chk(PRE_STAT_OFS, stat(4'h8, k ? BAD_TRIGGER : NULL_HANDLE),
             "preset fault");
      chk_word("counter kept", 32'h8000_0001, cnt_value);
      axi_write(PRE_CTRL_OFS, 32'h0);
      idle(4);
      rd_chk(PRE_STAT_OFS, 32'h0, "fault clear");
    end
    end_test("preset fault");
    stop_test();
  end
endmodule
